/* rtl/shutdown_wakeup_pkg.sv */
package shutdown_wakeup_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFF_CMD       = 8'h00;
    localparam logic [7:0]  OFF_CFG       = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h10;
    // Command register fields
    localparam int          KEY_LSB       = 24;
    localparam logic [7:0]  KEY_VALUE     = 8'hA5;
    localparam int          CMD_BIT       = 0;
    // Configuration register fields
    localparam int          EDGE_LSB      = 0;
    localparam int          DEB_LSB       = 4;
    localparam int          TIMER_EN_BIT  = 16;
    localparam int          CAL_EN_BIT    = 17;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0003;
    localparam logic [31:0] CFG_WMASK     = 32'h0003_00F3;
    // Status layout, shared by the interrupt status and mask
    localparam int          SEEN_BIT      = 0;
    localparam int          TIMER_BIT     = 16;
    localparam int          CAL_BIT       = 17;
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0] EVENT_MASK    = 32'h0003_0001;
    // Timing counts in slow clock cycles
    localparam logic [7:0]  DEB_UNIT      = 8'h10;
    localparam logic [1:0]  SHUT_DELAY    = 2'h2;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_ANY
    } wake_edge_e;
endpackage

/* rtl/shutdown_wakeup_controller.sv */
// Summary of operation
// RL1: Keyed write of the command bit asserts the power-off output.
// RL2: Command writes take effect only with key 0xA5; others are dropped.
// RL3: Power-off output asserts two slow clock cycles after the command.
// RL4: Edge select: 00 off, 01 rising, 10 falling, 11 any change.
// RL5: Selected wake edge starts counter; at count times 16 output releases.
// RL6: Another wake input change before the target stops and clears it. With edge select 11 the change restarts the count from zero instead.
// RL7: Release comes count times 16 plus one cycles after the event.
// RL8: Wake-input-seen status bit 0 sets on wake event, clears on read.
// RL9: Mode bit 16 lets a timer alarm rising edge release power-off.
// RL10: Mode bit 17 lets a calendar alarm rising edge release power-off.
// RL11: Timer-alarm-woke status bit 16 sets on enabled alarm, clears on read.
// RL12: Calendar-alarm-woke bit 17 sets on enabled alarm, clears on read.
// RL13: Software clears the timer alarm flag before shutting down.
// RL14: Software clears the calendar alarm flag before shutting down.
// RL15: Runs always on the slow clock; debounce count in mode bits 7:4.
// RL16: Power-off output stays asserted until a wake event releases it.
//
// Added by the designer: register access over AXI4-Lite.
module shutdown_wakeup_controller (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Wake sources, asynchronous
    input  wire logic        wake_input,
    input  wire logic        timer_alarm,
    input  wire logic        calendar_alarm,
    // Supply control and interrupt
    output logic             power_off_out,
    output logic             irq
);
    localparam int NSRC = 3;

    // Held bus requests
    logic        have_aw;
    logic        have_w;
    logic        have_ar;
    logic [7:0]  aw_addr;
    logic [7:0]  ar_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // Registers and state
    logic [31:0] cfg;
    logic [31:0] status;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [1:0]  shut_cnt;
    logic        deb_active;
    logic [7:0]  deb_cnt;

    // Synchronisers, one per asynchronous source
    logic [NSRC-1:0] raw_in;
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic [NSRC-1:0] sync3;
    logic [NSRC-1:0] level;
    logic [NSRC-1:0] loaded;
    logic [NSRC-1:0] chg;
    logic [2:0]      fill;

    assign raw_in = {calendar_alarm, timer_alarm, wake_input};

    // Marks when stage three first holds a real pin sample
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fill <= 3'h0;
        end else begin
            fill <= {fill[1:0], 1'b1};
        end
    end

    // Three stages; a change counts once stages two and three agree
    for (genvar i = 0; i < NSRC; i++) begin : g_sync
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                sync1[i]  <= 1'b0;
                sync2[i]  <= 1'b0;
                sync3[i]  <= 1'b0;
                level[i]  <= 1'b0;
                loaded[i] <= 1'b0;
            end else begin
                sync1[i] <= raw_in[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                // Reset contents of the stages are no pin sample
                if (fill[2] && sync2[i] == sync3[i]) begin
                    level[i]  <= sync3[i];
                    loaded[i] <= 1'b1;
                end
            end
        end
        // No edge before the first settled level, so idle-high is safe
        assign chg[i] = loaded[i] && (sync2[i] == sync3[i])
                        && (sync3[i] != level[i]);
    end

    // Bus handshakes and address decode
    wire aw_hs    = awvalid && awready;
    wire w_hs     = wvalid && wready;
    wire ar_hs    = arvalid && arready;
    wire wr_fire  = have_aw && have_w && !bvalid;
    wire rd_fire  = have_ar && !rvalid;
    wire next_have_aw = aw_hs || (have_aw && !wr_fire);
    wire next_have_w  = w_hs || (have_w && !wr_fire);
    wire next_have_ar = ar_hs || (have_ar && !rd_fire);

    wire w_cmd  = aw_addr[7:2] == shutdown_wakeup_pkg::OFF_CMD[7:2];
    wire w_cfg  = aw_addr[7:2] == shutdown_wakeup_pkg::OFF_CFG[7:2];
    wire w_stat = aw_addr[7:2] == shutdown_wakeup_pkg::OFF_STATUS[7:2];
    wire w_ist  = aw_addr[7:2] == shutdown_wakeup_pkg::OFF_IRQ_STAT[7:2];
    wire w_imk  = aw_addr[7:2] == shutdown_wakeup_pkg::OFF_IRQ_MASK[7:2];
    wire w_hit  = w_cmd || w_cfg || w_stat || w_ist || w_imk;

    wire r_cmd  = ar_addr[7:2] == shutdown_wakeup_pkg::OFF_CMD[7:2];
    wire r_cfg  = ar_addr[7:2] == shutdown_wakeup_pkg::OFF_CFG[7:2];
    wire r_stat = ar_addr[7:2] == shutdown_wakeup_pkg::OFF_STATUS[7:2];
    wire r_ist  = ar_addr[7:2] == shutdown_wakeup_pkg::OFF_IRQ_STAT[7:2];
    wire r_imk  = ar_addr[7:2] == shutdown_wakeup_pkg::OFF_IRQ_MASK[7:2];
    wire r_hit  = r_cmd || r_cfg || r_stat || r_ist || r_imk;

    // Byte-lane mask from the write strobes
    wire [31:0] lane = {{8{w_strb[3]}}, {8{w_strb[2]}},
                        {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Command needs the key lane and the command lane both written
    wire key_ok = w_data[shutdown_wakeup_pkg::KEY_LSB +: 8]
                  == shutdown_wakeup_pkg::KEY_VALUE;                // [RL2]
    wire cmd_ok = wr_fire && w_cmd && key_ok && w_strb[3] && w_strb[0]
                  && w_data[shutdown_wakeup_pkg::CMD_BIT];          // [RL1]

    // Configuration fields
    wire [1:0] edge_raw = cfg[shutdown_wakeup_pkg::EDGE_LSB +: 2];
    shutdown_wakeup_pkg::wake_edge_e wake_edge_select;
    assign wake_edge_select = shutdown_wakeup_pkg::wake_edge_e'(edge_raw);
    wire [3:0] wake_debounce_count = cfg[shutdown_wakeup_pkg::DEB_LSB +: 4];
    wire timer_alarm_wake_en    = cfg[shutdown_wakeup_pkg::TIMER_EN_BIT];
    wire calendar_alarm_wake_en = cfg[shutdown_wakeup_pkg::CAL_EN_BIT];

    // Wake edge qualification
    wire sel_edge = chg[0] && (
        (wake_edge_select == shutdown_wakeup_pkg::EDGE_ANY) ||
        (wake_edge_select == shutdown_wakeup_pkg::EDGE_RISE && sync3[0]) ||
        (wake_edge_select == shutdown_wakeup_pkg::EDGE_FALL && !sync3[0])
    );                                                              // [RL4]
    wire [7:0] deb_target = {4'h0, wake_debounce_count}
                            * shutdown_wakeup_pkg::DEB_UNIT;        // [RL15]
    // Hit one cycle before release gives the extra cycle
    wire deb_hit = deb_active && !chg[0]
                   && (deb_cnt == deb_target);                      // [RL7]

    // Alarm rising edges, only when enabled
    wire tim_rise = chg[1] && sync3[1] && timer_alarm_wake_en;      // [RL9]
    wire cal_rise = chg[2] && sync3[2] && calendar_alarm_wake_en;   // [RL10]
    wire release_req = deb_hit || tim_rise || cal_rise;

    // Event vector in status layout
    wire [31:0] ev = {14'h0, cal_rise, tim_rise, 15'h0, deb_hit};

    // Status clears on read; a same-cycle event still sets
    wire [31:0] rd_clr = (rd_fire && r_stat) ? 32'hFFFF_FFFF : 32'h0;
    wire [31:0] next_status = (status & ~rd_clr) | ev; // [RL8][RL11][RL12]
    wire [31:0] w1c = (wr_fire && w_ist) ? (w_data & lane) : 32'h0;
    wire [31:0] next_irq_status = (irq_status & ~w1c) | ev;

    // Read data selection
    wire [31:0] rd_mux = r_cfg  ? cfg :
                         r_stat ? status :
                         r_ist  ? irq_status :
                         r_imk  ? irq_mask : 32'h0;

    // Request holding and ready flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            have_aw <= 1'b0;
            have_w  <= 1'b0;
            have_ar <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            arready <= 1'b0;
        end else begin
            have_aw <= next_have_aw;
            have_w  <= next_have_w;
            have_ar <= next_have_ar;
            awready <= !next_have_aw;
            wready  <= !next_have_w;
            arready <= !next_have_ar;
        end
    end

    // Captured address and data, no reset needed for payload
    always_ff @(posedge mclk) begin
        if (aw_hs) aw_addr <= awaddr;
        if (w_hs) begin
            w_data <= wdata;
            w_strb <= wstrb;
        end
        if (ar_hs) ar_addr <= araddr;
    end

    // Write response
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= shutdown_wakeup_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= w_hit ? shutdown_wakeup_pkg::RESP_OKAY
                            : shutdown_wakeup_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read response; data frozen while rvalid stands
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= shutdown_wakeup_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= r_hit ? shutdown_wakeup_pkg::RESP_OKAY
                            : shutdown_wakeup_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Software registers; writes honour byte lanes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg      <= shutdown_wakeup_pkg::CFG_RESET;
            irq_mask <= shutdown_wakeup_pkg::STATUS_RESET;
        end else if (wr_fire) begin
            if (w_cfg)
                cfg <= ((cfg & ~lane) | (w_data & lane))
                       & shutdown_wakeup_pkg::CFG_WMASK;
            if (w_imk)
                irq_mask <= ((irq_mask & ~lane) | (w_data & lane))
                            & shutdown_wakeup_pkg::EVENT_MASK;
        end
    end

    // Sticky flags and interrupt line
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status     <= shutdown_wakeup_pkg::STATUS_RESET;
            irq_status <= shutdown_wakeup_pkg::STATUS_RESET;
            irq        <= 1'b0;
        end else begin
            status     <= next_status;
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_mask);
        end
    end

    // Wake debounce counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            deb_active <= 1'b0;
            deb_cnt    <= 8'h00;
        end else if (sel_edge) begin
            deb_active <= 1'b1;                                     // [RL5]
            deb_cnt    <= 8'h00;
        end else if (chg[0] ||
                     wake_edge_select == shutdown_wakeup_pkg::EDGE_NONE) begin
            deb_active <= 1'b0;                                     // [RL6]
            deb_cnt    <= 8'h00;
        end else if (deb_hit) begin
            deb_active <= 1'b0;
            deb_cnt    <= 8'h00;
        end else if (deb_active) begin
            deb_cnt <= deb_cnt + 8'h01;                             // [RL5]
        end
    end

    // Power-off output; a pending command beats a same-cycle release
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shut_cnt      <= 2'h0;
            power_off_out <= 1'b0;
        end else begin
            if (cmd_ok)
                shut_cnt <= shutdown_wakeup_pkg::SHUT_DELAY;        // [RL3]
            else if (shut_cnt != 2'h0)
                shut_cnt <= shut_cnt - 2'h1;
            if (shut_cnt == 2'h1)
                power_off_out <= 1'b1;                              // [RL1]
            else if (release_req)
                power_off_out <= 1'b0;                              // [RL16]
        end
    end
endmodule

/* sim/supply_wake_model.sv */
module supply_wake_model (
    // Requests from the bench
    input  wire logic press,
    input  wire logic timer_req,
    input  wire logic cal_req,
    // Pins seen by the controller
    output logic      wake_input,
    output logic      timer_alarm,
    output logic      calendar_alarm
);
    timeunit 1ns;
    timeprecision 1ps;
    // Button with pull-down, so a released button reads low
    assign wake_input = press;
    // Alarm flags; cleared by software before every shutdown
    assign timer_alarm = timer_req;
    assign calendar_alarm = cal_req;
endmodule

/* sim/shutdown_wakeup_asserts.sv */
module shutdown_wakeup_asserts (
    // Clock and reset
    input wire logic        mclk, rst,
    // Write channels
    input wire logic [7:0]  awaddr,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        awvalid, awready, wvalid, wready, bvalid,
    // Wake sources and supply control
    input wire logic        wake_input, timer_alarm, calendar_alarm,
    input wire logic        power_off_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  caddr;
    logic [31:0] cdata, cfg;
    logic [3:0]  cstrb;
    logic        bv_d, wk_d;
    logic [11:0] wcnt;
    // Decode of the write that just got its response
    wire bfire = bvalid && !bv_d;
    wire cmd_sel = caddr == shutdown_wakeup_pkg::OFF_CMD
                   && cstrb[3] && cstrb[0];
    wire key_ok = cdata[31:24] == shutdown_wakeup_pkg::KEY_VALUE;
    wire cmd_fire = bfire && cmd_sel && key_ok && cdata[0];
    wire bad_key = bfire && cmd_sel && !key_ok;
    wire cfg_fire = bfire && caddr == shutdown_wakeup_pkg::OFF_CFG;
    wire [1:0] edge_sel = cfg[1:0];
    wire [11:0] deb_cyc = {4'h0, cfg[7:4], 4'h0};
    wire ten = cfg[16];
    wire cen = cfg[17];
    // Shadow config lags the design by one cycle; margins allow for it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            caddr <= 8'h00;
            cdata <= 32'h0000_0000;
            cstrb <= 4'h0;
            cfg <= shutdown_wakeup_pkg::CFG_RESET;
            bv_d <= 1'b0;
            wk_d <= 1'b0;
            wcnt <= 12'h000;
        end else begin
            if (awvalid && awready) caddr <= awaddr;
            if (wvalid && wready) cdata <= wdata;
            if (wvalid && wready) cstrb <= wstrb;
            if (cfg_fire) cfg <= cdata & shutdown_wakeup_pkg::CFG_WMASK;
            bv_d <= bvalid;
            wk_d <= wake_input;
            // Cycles since the pin last moved, saturating
            wcnt <= (wake_input != wk_d) ? 12'h000 : wcnt + {11'h000, ~&wcnt};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_cmd_delay: assert property (cmd_fire && !power_off_out |=>
        !power_off_out ##1 power_off_out) else $error("late shutdown");
    a_bad_key: assert property (bad_key && !power_off_out |=>
        !power_off_out [*3]) else $error("wrong key accepted");
    a_rise_cause: assert property ($rose(power_off_out) |->
        $past(cmd_fire, 2)) else $error("shutdown without command");
    a_edge_none: assert property (power_off_out && edge_sel == 2'h0 &&
        !ten && !cen |=> power_off_out) else $error("release while off");
    a_release_time: assert property ($fell(power_off_out)
        && !ten && !cen |-> wcnt >= deb_cyc && wcnt <= deb_cyc + 12'h006)
        else $error("debounce timing wrong");
    a_timer_wake: assert property (power_off_out && ten &&
        $rose(timer_alarm) |-> ##[1:6] !power_off_out)
        else $error("timer alarm did not wake");
    a_cal_wake: assert property (power_off_out && cen &&
        $rose(calendar_alarm) |-> ##[1:6] !power_off_out)
        else $error("calendar alarm did not wake");
    a_alarm_off: assert property (power_off_out && !ten &&
        !cen && edge_sel == 2'h0 &&
        ($rose(timer_alarm) || $rose(calendar_alarm))
        |=> power_off_out [*6]) else $error("disabled alarm woke");
    c_cmd: cover property (cmd_fire);
    c_release: cover property ($fell(power_off_out));
    c_timer: cover property (power_off_out && ten && $rose(timer_alarm));
endmodule
bind shutdown_wakeup_controller shutdown_wakeup_asserts shutdown_wakeup_asserts_i (
    .mclk, .rst, .awaddr, .wdata, .wstrb, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .wake_input, .timer_alarm, .calendar_alarm,
    .power_off_out);

/* sim/shutdown_wakeup_controller_tb_top.sv */
module shutdown_wakeup_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CMD = shutdown_wakeup_pkg::OFF_CMD;
    localparam logic [7:0] CFG = shutdown_wakeup_pkg::OFF_CFG;
    localparam logic [7:0] STA = shutdown_wakeup_pkg::OFF_STATUS;
    localparam logic [7:0] IST = shutdown_wakeup_pkg::OFF_IRQ_STAT;
    localparam logic [7:0] IMK = shutdown_wakeup_pkg::OFF_IRQ_MASK;
    localparam logic [1:0] OK = shutdown_wakeup_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = shutdown_wakeup_pkg::RESP_SLVERR;
    localparam logic [31:0] GO = 32'hA500_0001;
    logic        mclk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        press = 1'b0, timer_req = 1'b0, cal_req = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, power_off_out;
    logic        wake_input, timer_alarm, calendar_alarm;
    logic [1:0]  bresp, rresp;
    int          mismatches = 0, compares = 0;
    always #5 mclk = ~mclk;
    shutdown_wakeup_controller shutdown_wakeup_controller_i (.mclk, .rst,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .wake_input, .timer_alarm,
        .calendar_alarm, .power_off_out, .irq);
    supply_wake_model supply_wake_model_i (.press, .timer_req, .cal_req,
        .wake_input, .timer_alarm, .calendar_alarm);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Readies are sampled at the falling edge, where they are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        logic ta, tw, da, dw;
        n = 0;
        da = 1'b0;
        dw = 1'b0;
        @(posedge mclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(da && dw) && n < 100) begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = da || ta;
            dw = dw || tw;
            n++;
        end
        do @(negedge mclk); while (bvalid !== 1'b1 && n++ < 200);
        // A response that never came counts as a mismatch
        check({31'h0, bvalid}, 32'h1);
        check({30'h0, bresp}, {30'h0, er});
        @(posedge mclk) bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(negedge mclk); while (arready !== 1'b1 && n++ < 100);
        @(posedge mclk) arvalid <= 1'b0;
        do @(negedge mclk); while (rvalid !== 1'b1 && n++ < 200);
        check({31'h0, rvalid}, 32'h1);
        check(rdata, e);
        check({30'h0, rresp}, {30'h0, OK});
        @(posedge mclk) rready <= 1'b0;
    endtask
    // Lets the edge updates land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end
    initial begin
        int i, n;
        logic [1:0] m;
        logic up, ex;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        settle(2);
        rd(CFG, shutdown_wakeup_pkg::CFG_RESET);
        rd(STA, 32'h0000_0000);
        wr(8'h14, 32'hFFFF_FFFF, ERR);
        wr(STA, 32'hFFFF_FFFF, OK);
        rd(STA, 32'h0000_0000);
        wr(CFG, 32'hFFFF_FFFF, OK);
        rd(CFG, shutdown_wakeup_pkg::CFG_WMASK);
        wr(CFG, 32'h0000_0021, OK);
        wr(CMD, 32'h5A00_0001, OK);
        settle(6);
        check(power_off_out, 1'b0);
        wr(CMD, GO, OK);
        settle(3);
        check(power_off_out, 1'b1);
        // Pulse shorter than the debounce window must not wake
        @(posedge mclk) press <= 1'b1;
        repeat (20) @(posedge mclk);
        press <= 1'b0;
        settle(60);
        check(power_off_out, 1'b1);
        @(posedge mclk) press <= 1'b1;
        n = 0;
        do @(negedge mclk); while (power_off_out && n++ < 100);
        check({31'h0, n inside {[33:38]}}, 32'h1);
        rd(STA, 32'h0000_0001);
        rd(STA, 32'h0000_0000);
        // Every edge mode against both pin directions, no debounce
        for (i = 0; i < 8; i++) begin
            m = i[2:1];
            up = !press;
            ex = m == 2'h3 || (m == 2'h1 && up) || (m == 2'h2 && !up);
            wr(CFG, {30'h0, m}, OK);
            wr(CMD, GO, OK);
            @(posedge mclk) press <= up;
            settle(12);
            check(power_off_out, !ex);
            rd(STA, {31'h0, ex});
        end
        // Both alarms, disabled then enabled
        for (i = 0; i < 4; i++) begin
            ex = i[0];
            wr(CFG, ex ? 32'h1 << (16 + i[1]) : 32'h0, OK);
            wr(CMD, GO, OK);
            @(posedge mclk) {cal_req, timer_req} <= i[1] ? 2'h2 : 2'h1;
            settle(10);
            check(power_off_out, !ex);
            rd(STA, ex ? 32'h1 << (16 + i[1]) : 32'h0);
            @(posedge mclk) {cal_req, timer_req} <= 2'h0;
        end
        // Interrupt raised, masked, unmasked and cleared
        wr(IST, 32'h0003_0001, OK);
        wr(IMK, 32'h0000_0001, OK);
        wr(CFG, 32'h0000_0003, OK);
        @(posedge mclk) press <= !press;
        settle(10);
        check(irq, 1'b1);
        wr(IMK, 32'h0000_0000, OK);
        settle(2);
        check(irq, 1'b0);
        wr(IMK, 32'h0000_0001, OK);
        settle(2);
        check(irq, 1'b1);
        wr(IST, 32'h0000_0001, OK);
        settle(2);
        check(irq, 1'b0);
        rd(IST, 32'h0000_0000);
        wrap_up();
    end
endmodule
